// ---- pldsec_pkg.sv ----
// constants and types for the power-up, signature and security support block
//======================================================================
// Summary of operation
// R1: all internal registers cleared to zero within 45 us of power-up.
// R2: registered outputs read low after clear; post-register inverted cells read high (code: only where active_low_cfg is also set).
// R3: system should not clock the device before setup intervals are met.
// R4: first valid clock edge comes no sooner than 100 ns after power-up.
// R5: sixteen-byte user identification memory, written freely, read back by verify.
// R6: programmed security cell refuses array programming and blocks array verify readout.
// R7: security cell cleared only by bulk erase of the whole device (code: sec_r is also cleared by rst_n).
// R8: every macrocell register accepts a forced arbitrary load during functional test.
// R9: register preload reachable only through the programming and test path.
package pldsec_pkg;
   localparam int PLDSEC_CLK_PERIOD_NS = 10;
   localparam int PLDSEC_CLEAR_TIME_US = 45;
   localparam int PLDSEC_CLEAR_CYCLES = (PLDSEC_CLEAR_TIME_US * 1000) / PLDSEC_CLK_PERIOD_NS;
   localparam int PLDSEC_CLK_VALID_NS = 100;
   localparam int PLDSEC_CLK_VALID_CYCLES =
      (PLDSEC_CLK_VALID_NS + PLDSEC_CLK_PERIOD_NS - 1) / PLDSEC_CLK_PERIOD_NS;
   localparam int PLDSEC_ID_BYTES = 16;
   localparam int PLDSEC_ID_AW = 4;
   localparam logic [7:0] PLDSEC_ID_RESET = 8'h00;
   typedef enum logic [2:0]
   {
      PLDSEC_CMD_NOP,
      PLDSEC_CMD_PROG_ARRAY,
      PLDSEC_CMD_VERIFY_ARRAY,
      PLDSEC_CMD_PROG_ID,
      PLDSEC_CMD_VERIFY_ID,
      PLDSEC_CMD_SET_SECURITY,
      PLDSEC_CMD_BULK_ERASE,
      PLDSEC_CMD_PRELOAD
   } pldsec_cmd_t;
   typedef enum {PLDSEC_ST_CLEAR, PLDSEC_ST_WAIT_CLK, PLDSEC_ST_RUN} pldsec_state_t;
endpackage

// ---- pldsec_prog_if.sv ----
// programming path signals between the top and the identification memory
`timescale 1ns/1ps
interface pldsec_prog_if;
   logic wr_en;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic erase;
   modport ctrl (output wr_en, output addr, output wdata, output erase, input rdata);
   modport mem (input wr_en, input addr, input wdata, input erase, output rdata);
endinterface

// ---- pldsec_id_mem.sv ----
// user identification memory, sixteen bytes
`timescale 1ns/1ps
module pldsec_id_mem
   import pldsec_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   pldsec_prog_if.mem pif
);
   logic [7:0] mem_r [PLDSEC_ID_BYTES];
   logic [7:0] rdata_r;
   assign pif.rdata = rdata_r;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < PLDSEC_ID_BYTES; i++)
            mem_r[i] <= PLDSEC_ID_RESET;
         rdata_r <= 8'h00;
      end
      else
      begin
         if (pif.erase)
            for (int i = 0; i < PLDSEC_ID_BYTES; i++)
               mem_r[i] <= PLDSEC_ID_RESET;
         else if (pif.wr_en)
            mem_r[pif.addr] <= pif.wdata; // R5
         rdata_r <= mem_r[pif.addr]; // R5
      end
   end
endmodule

// ---- pldsec_top.sv ----
// power-up clear, security cell, preload path and verify readout
`timescale 1ns/1ps
module pldsec_top
   import pldsec_pkg::*;
#(
   parameter int NREG = 8,
   parameter int CLEAR_CYCLES = PLDSEC_CLEAR_CYCLES
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [2:0] prog_cmd,
   input wire logic prog_valid,
   input wire logic [3:0] prog_addr,
   input wire logic [7:0] prog_wdata,
   input wire logic [NREG-1:0] preload_data,
   input wire logic [NREG-1:0] reg_next,
   input wire logic [NREG-1:0] oe_cfg,
   input wire logic [NREG-1:0] inv_after_reg,
   input wire logic [NREG-1:0] active_low_cfg,
   output logic [7:0] verify_data,
   output logic verify_valid,
   output logic prog_refused,
   output logic security_set,
   output logic clear_done,
   output logic clock_ready,
   output logic [NREG-1:0] reg_q,
   output logic [NREG-1:0] pin_out,
   output logic [NREG-1:0] pin_oe
);
   initial
   begin
      if (NREG < 1 || NREG > 8)
         $error("NREG must be 1..8");
      if (CLEAR_CYCLES < 1)
         $error("CLEAR_CYCLES must be at least 1");
   end

   //======================================================================
   // power-up sequencing
   pldsec_state_t state_r, state_nxt;
   logic [31:0] cnt_r, cnt_nxt;
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r + 32'h0000_0001;
      case (state_r)
         PLDSEC_ST_CLEAR:
            if (cnt_r >= 32'(CLEAR_CYCLES - 1)) // R1
            begin
               state_nxt = PLDSEC_ST_WAIT_CLK;
               cnt_nxt = 32'h0000_0000;
            end
         PLDSEC_ST_WAIT_CLK:
            if (cnt_r >= 32'(PLDSEC_CLK_VALID_CYCLES - 1)) // R4
               state_nxt = PLDSEC_ST_RUN;
         default:
            cnt_nxt = cnt_r;
      endcase
   end
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= PLDSEC_ST_CLEAR;
         cnt_r <= 32'h0000_0000;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   wire in_clear = (state_r == PLDSEC_ST_CLEAR);
   assign clear_done = !in_clear;
   assign clock_ready = (state_r == PLDSEC_ST_RUN); // R3 R4

   //======================================================================
   // command decode
   wire cmd_ok = prog_valid && clock_ready;
   wire c_prog = cmd_ok && (prog_cmd == PLDSEC_CMD_PROG_ARRAY);
   wire c_ver = cmd_ok && (prog_cmd == PLDSEC_CMD_VERIFY_ARRAY);
   wire c_pid = cmd_ok && (prog_cmd == PLDSEC_CMD_PROG_ID);
   wire c_vid = cmd_ok && (prog_cmd == PLDSEC_CMD_VERIFY_ID);
   wire c_sec = cmd_ok && (prog_cmd == PLDSEC_CMD_SET_SECURITY);
   wire c_erase = cmd_ok && (prog_cmd == PLDSEC_CMD_BULK_ERASE);
   wire c_pre = cmd_ok && (prog_cmd == PLDSEC_CMD_PRELOAD); // R9

   //======================================================================
   // security cell and array image
   logic sec_r;
   logic [7:0] array_r [PLDSEC_ID_BYTES];
   logic [7:0] aread_r;
   logic ver_sel_r, vld_r, ref_r;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sec_r <= 1'b0;
         for (int i = 0; i < PLDSEC_ID_BYTES; i++)
            array_r[i] <= 8'h00;
         aread_r <= 8'h00;
         ver_sel_r <= 1'b0;
         vld_r <= 1'b0;
         ref_r <= 1'b0;
      end
      else
      begin
         if (c_erase)
         begin
            sec_r <= 1'b0; // R7
            for (int i = 0; i < PLDSEC_ID_BYTES; i++)
               array_r[i] <= 8'h00;
         end
         else
         begin
            if (c_sec)
               sec_r <= 1'b1;
            if (c_prog && !sec_r) // R6
               array_r[prog_addr] <= prog_wdata;
         end
         aread_r <= sec_r ? 8'h00 : array_r[prog_addr]; // R6
         ver_sel_r <= c_vid;
         vld_r <= (c_ver && !sec_r) || c_vid;
         ref_r <= (c_prog || c_ver) && sec_r; // R6
      end
   end
   assign security_set = sec_r;
   assign verify_valid = vld_r;
   assign prog_refused = ref_r;

   //======================================================================
   // identification memory
   pldsec_prog_if pif ();
   assign pif.wr_en = c_pid; // R5
   assign pif.addr = prog_addr;
   assign pif.wdata = prog_wdata;
   assign pif.erase = c_erase;
   pldsec_id_mem u_id
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pif(pif.mem)
   );
   assign verify_data = ver_sel_r ? pif.rdata : aread_r;

   //======================================================================
   // macrocell registers with preload
   logic [NREG-1:0] q_r;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         q_r <= '0; // R1
      else if (in_clear)
         q_r <= '0; // R1
      else if (c_pre)
         q_r <= preload_data; // R8 R9
      else if (clock_ready)
         q_r <= reg_next;
   end
   assign reg_q = q_r;
   genvar g;
   generate
      for (g = 0; g < NREG; g++)
      begin : g_pin
         assign pin_out[g] = inv_after_reg[g] ? (q_r[g] ^ active_low_cfg[g]) : q_r[g]; // R2
         assign pin_oe[g] = oe_cfg[g];
      end
   endgenerate
endmodule

// ---- pldsec_top_checker.sv ----
// assertions on the ports of the power-up and security block
`timescale 1ns/1ps
module pldsec_top_checker
#(
   parameter int NREG = 8
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [2:0] prog_cmd,
   input wire logic prog_valid,
   input wire logic [NREG-1:0] preload_data,
   input wire logic [NREG-1:0] oe_cfg,
   input wire logic [NREG-1:0] inv_after_reg,
   input wire logic [NREG-1:0] active_low_cfg,
   input wire logic verify_valid,
   input wire logic prog_refused,
   input wire logic security_set,
   input wire logic clear_done,
   input wire logic clock_ready,
   input wire logic [NREG-1:0] reg_q,
   input wire logic [NREG-1:0] pin_out,
   input wire logic [NREG-1:0] pin_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire go = prog_valid && clock_ready;
   AST_CLEAR_ZERO: assert property (!clear_done |-> reg_q == '0)
      else $error("register not clear");
   AST_PIN_POL: assert property (pin_out == (reg_q ^ (inv_after_reg & active_low_cfg)))
      else $error("pin polarity wrong");
   AST_PIN_OE: assert property (pin_oe == oe_cfg)
      else $error("pin enable wrong");
   AST_CLK_WAIT: assert property ($rose(clear_done) |-> !clock_ready [*8])
      else $error("clock ready too early");
   AST_CLK_BOUND: assert property ($rose(clear_done) |-> ##[1:12] clock_ready)
      else $error("clock ready too late");
   AST_VERIFY: assert property (go && prog_cmd == 3'h4 |=> verify_valid)
      else $error("no id readout");
   AST_REFUSE: assert property (go && security_set && prog_cmd inside {3'h1, 3'h2}
      |=> prog_refused && !verify_valid)
      else $error("secured access not refused");
   AST_SEC_KEEP: assert property (security_set && !(go && prog_cmd == 3'h6) |=> security_set)
      else $error("security lost");
   AST_PRELOAD: assert property (go && prog_cmd == 3'h7 |=> reg_q == $past(preload_data))
      else $error("preload missed");
   AST_NO_EARLY: assert property (!clock_ready |=> !verify_valid && !prog_refused)
      else $error("command taken early");
endmodule
bind pldsec_top pldsec_top_checker #(.NREG(NREG)) chk_i (.*);

// ---- pldsec_prog_model.sv ----
// programming equipment model driving commands
`timescale 1ns/1ps
module pldsec_prog_model
   import pldsec_pkg::*;
(
   input wire logic clk_sys,
   input wire logic clock_ready,
   output logic [2:0] prog_cmd,
   output logic prog_valid,
   output logic [3:0] prog_addr,
   output logic [7:0] prog_wdata
);
   initial
   begin
      prog_cmd = 3'h0;
      prog_valid = 1'b0;
      prog_addr = 4'h0;
      prog_wdata = 8'h00;
   end
   task automatic issue(input pldsec_cmd_t c, input logic [3:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      while (!clock_ready) @(negedge clk_sys);
      prog_cmd = c;
      prog_addr = a;
      prog_wdata = d;
      prog_valid = 1'b1;
      @(negedge clk_sys);
      prog_valid = 1'b0;
      prog_wdata = ~d;
   endtask
endmodule

// ---- pldsec_top_tb.sv ----
// self-checking bench for the power-up and security block
`timescale 1ns/1ps
module pldsec_top_tb
   import pldsec_pkg::*;
;
   localparam int NREG = 8;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   wire [2:0] prog_cmd;
   wire prog_valid;
   wire [3:0] prog_addr;
   wire [7:0] prog_wdata;
   logic [7:0] preload_data, reg_next, oe_cfg, inv_after_reg, active_low_cfg;
   logic [7:0] verify_data, reg_q, pin_out, pin_oe, d;
   logic verify_valid, prog_refused, security_set, clear_done, clock_ready;
   logic [7:0] id_m [16];
   int errors = 0;
   int samples_checked = 0;
   int seed = 25522;
   pldsec_top #(.NREG(NREG), .CLEAR_CYCLES(20)) dut (.*);
   pldsec_prog_model pm (.*);
   always #5 clk_sys = ~clk_sys;
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic stop_test;
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      #50000;
      errors++;
      stop_test;
   end
   initial
   begin
      {oe_cfg, inv_after_reg, active_low_cfg} = 24'($random(seed));
      reg_next = 8'($random(seed));
      preload_data = 8'($random(seed));
      repeat (16) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (22) @(negedge clk_sys);
      chk("clear", 8'h01, {7'h0, clear_done});
      chk("ready", 8'h00, {7'h0, clock_ready});
      chk("reg_q", 8'h00, reg_q);
      chk("pin_out", inv_after_reg & active_low_cfg, pin_out);
      chk("pin_oe", oe_cfg, pin_oe);
      pm.issue(PLDSEC_CMD_PRELOAD, 4'h0, 8'h00);
      chk("preload", preload_data, reg_q);
      chk("pin_pre", preload_data ^ (inv_after_reg & active_low_cfg), pin_out);
      @(negedge clk_sys);
      chk("run", reg_next, reg_q);
      for (int i = 0; i < 16; i++)
      begin
         id_m[i] = 8'($random(seed));
         pm.issue(PLDSEC_CMD_PROG_ID, i[3:0], id_m[i]);
      end
      for (int i = 0; i < 16; i++)
      begin
         pm.issue(PLDSEC_CMD_VERIFY_ID, i[3:0], 8'h00);
         chk("id", id_m[i], verify_data);
      end
      d = 8'($random(seed));
      pm.issue(PLDSEC_CMD_PROG_ARRAY, 4'h3, d);
      pm.issue(PLDSEC_CMD_VERIFY_ARRAY, 4'h3, 8'h00);
      chk("array", d, verify_data);
      pm.issue(PLDSEC_CMD_SET_SECURITY, 4'h0, 8'h00);
      chk("secure", 8'h01, {7'h0, security_set});
      pm.issue(PLDSEC_CMD_PROG_ARRAY, 4'h3, ~d);
      chk("refused", 8'h01, {7'h0, prog_refused});
      pm.issue(PLDSEC_CMD_VERIFY_ARRAY, 4'h3, 8'h00);
      chk("blocked", 8'h00, {7'h0, verify_valid});
      pm.issue(PLDSEC_CMD_NOP, 4'h0, 8'h00);
      chk("kept", 8'h01, {7'h0, security_set});
      pm.issue(PLDSEC_CMD_BULK_ERASE, 4'h0, 8'h00);
      chk("erased", 8'h00, {7'h0, security_set});
      pm.issue(PLDSEC_CMD_VERIFY_ARRAY, 4'h3, 8'h00);
      chk("array_clr", 8'h00, verify_data);
      stop_test;
   end
endmodule
